// *** src/esirs_pkg.sv ***
// Package for the external step input and jerk scaling block
package esirs_pkg;

    // ==================================================
    // Register map (byte addresses are four times index)
    localparam logic [7:0] ESIRS_IDX_GEN_CONF = 8'h00;
    localparam logic [7:0] ESIRS_IDX_GEARING = 8'h12;
    localparam logic [7:0] ESIRS_IDX_CLOCK_FREQUENCY_SETTING = 8'h31;
    localparam logic [7:0] ESIRS_IDX_JERK1 = 8'h2d;
    localparam logic [7:0] ESIRS_IDX_STATUS = 8'h40;
    localparam logic [7:0] ESIRS_IDX_STEP_CNT = 8'h41;
    localparam logic [7:0] ESIRS_NUM_JERK = 8'd4;

    // ==================================================
    // Field positions in general_configuration
    localparam int ESIRS_SDIN_MODE_LSB = 6;
    localparam int ESIRS_POL_DIR_BIT = 8;
    localparam int ESIRS_DIRECT_BOW_BIT = 9;
    localparam int ESIRS_DIRECT_ACC_BIT = 26;

    // ==================================================
    // Reset values
    localparam logic [31:0] ESIRS_GEN_CONF_RST = 32'h0000_0000;
    localparam logic [31:0] ESIRS_GEARING_RST = 32'h0100_0000;
    localparam logic [31:0] ESIRS_CLOCK_FREQUENCY_SETTING_RST = 32'h00F4_2400;
    localparam logic [23:0] ESIRS_JERK_RST = 24'h00_0000;

    // ==================================================
    // Scaling constants
    localparam int ESIRS_JERK_W = 24;
    localparam int ESIRS_DIRECT_JERK_SHIFT = 53;
    localparam int ESIRS_DIRECT_ACC_SHIFT = 37;
    localparam int ESIRS_LIMIT_DIV_SHIFT = 10;
    localparam logic [23:0] ESIRS_DIRECT_JERK_MAX = 24'h10_0000;

    localparam logic [1:0] AXI_OKAY = 2'b00;
    localparam logic [1:0] AXI_SLVERR = 2'b10;

    typedef enum logic [1:0] {
        ESIRS_SRC_INTERNAL = 2'b00,
        ESIRS_SRC_RISE = 2'b01,
        ESIRS_SRC_FALL = 2'b10,
        ESIRS_SRC_TOGGLE = 2'b11
    } esirs_src_e;

    typedef struct packed {
        logic step;
        logic dir_pos;
    } esirs_step_s;

endpackage

// *** src/esirs_sync.sv ***
// Two-stage synchroniser for one level
`timescale 1ns/1ps
module esirs_sync (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic async_i,
    output logic sync_o
);
    logic meta_q;

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_q <= 1'b0;
            sync_o <= 1'b0;
        end else begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end
endmodule

// *** src/esirs_jerk_mem.sv ***
// Small register memory holding the four jerk values
`timescale 1ns/1ps
module esirs_jerk_mem
    import esirs_pkg::*;
#(
    parameter int DEPTH = 4,
    parameter int WIDTH = 24
) (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic wr_en_i,
    input wire logic [1:0] wr_addr_i,
    input wire logic [WIDTH-1:0] wr_data_i,
    input wire logic [1:0] rd_addr_i,
    output logic [WIDTH-1:0] rd_data_o
);
    logic [WIDTH-1:0] mem_q [DEPTH];

    if (DEPTH < 1 || DEPTH > 4) begin : g_depth_chk
        $error("Depth must be 1..4");
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= '0;
            end
        end else if (wr_en_i) begin
            mem_q[wr_addr_i] <= wr_data_i;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_data_o <= '0;
        end else begin
            rd_data_o <= mem_q[rd_addr_i];
        end
    end
endmodule

// *** src/esirs_top.sv ***
// External step input front end with jerk value scaling registers
//
// Notes on behaviour
// - Direct jerk flag set: jerk values are per-cycle acceleration change, MSB 2^-30.
// - Direct jerk flag clear: jerk values are 24-bit integers in pulses/s^3.
// - Direct jerk: jerk equals value over 2^53 times clock frequency cubed.
// - Direct accel: velocity change over 2^37 times clock squared.
// - Any external step mode disables the internal step generator.
// - Mode 01 counts one step per rising edge of the step pin.
// - Mode 10 counts one step per falling edge of the step pin.
// - Mode 11 counts one step on every step pin edge.
// - Mode 00 turns external input off; internal ramp drives steps.
// - Direction low means negative; polarity flag inverts this.
// - Gearing factor at 0x12 is signed 8.24, read and write.
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ps
module esirs_top
    import esirs_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // AXI4-Lite slave
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Step/direction link
    input wire logic ext_step_pin_i,
    input wire logic ext_direction_pin_i,
    input wire logic int_step_i,
    input wire logic int_dir_pos_i,
    output logic step_o,
    output logic dir_pos_o,
    output logic ext_mode_o,
    output logic direct_jerk_o,
    output logic direct_accel_o,
    output logic [31:0] gearing_factor_o,
    output logic [31:0] clock_frequency_setting_o
);
    // The upper address bits above bit 9 are decoded, so fewer than 11 cannot work
    if (ADDR_W < 11) begin : g_addr_chk
        $error("Address width too small for register map");
    end

    // ==================================================
    // Register storage
    logic [31:0] gen_conf_q;
    logic [31:0] gearing_q;
    logic [31:0] clock_frequency_setting_q;
    logic [31:0] step_cnt_q;
    logic [31:0] rdata_d;
    logic rd_ok_d;
    logic [23:0] jerk_rd;

    function automatic logic [7:0] word_index(input logic [ADDR_W-1:0] a);
        return a[9:2];
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) r[i*8 +: 8] = nw[i*8 +: 8];
        end
        return r;
    endfunction

    function automatic logic is_jerk(input logic [7:0] idx);
        return idx >= ESIRS_IDX_JERK1 && idx < ESIRS_IDX_JERK1 + ESIRS_NUM_JERK;
    endfunction

    // ==================================================
    // Write channel: address and data taken in either order
    logic aw_have_q;
    logic w_have_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic wr_fire;
    logic [7:0] wr_idx;
    logic wr_hit;

    assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
    assign wr_idx = word_index(awaddr_q);
    assign wr_hit = (awaddr_q[1:0] == 2'b00) && awaddr_q[ADDR_W-1:10] == '0 &&
                    (wr_idx == ESIRS_IDX_GEN_CONF || wr_idx == ESIRS_IDX_GEARING ||
                     wr_idx == ESIRS_IDX_CLOCK_FREQUENCY_SETTING || is_jerk(wr_idx));

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            aw_have_q <= 1'b0;
            awaddr_q <= '0;
            s_axi_awready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_have_q && !s_axi_awready;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end else if (wr_fire) begin
                aw_have_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            w_have_q <= 1'b0;
            wdata_q <= '0;
            wstrb_q <= '0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_wready <= !w_have_q && !s_axi_wready;
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end else if (wr_fire) begin
                w_have_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= AXI_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? AXI_OKAY : AXI_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Configuration registers
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            gen_conf_q <= ESIRS_GEN_CONF_RST;
            gearing_q <= ESIRS_GEARING_RST;
            clock_frequency_setting_q <= ESIRS_CLOCK_FREQUENCY_SETTING_RST;
        end else if (wr_fire && wr_hit) begin
            if (wr_idx == ESIRS_IDX_GEN_CONF) gen_conf_q <= merge(gen_conf_q, wdata_q, wstrb_q);
            if (wr_idx == ESIRS_IDX_GEARING) gearing_q <= merge(gearing_q, wdata_q, wstrb_q);
            if (wr_idx == ESIRS_IDX_CLOCK_FREQUENCY_SETTING) clock_frequency_setting_q <= merge(clock_frequency_setting_q, wdata_q, wstrb_q);
        end
    end

    // Jerk values: 24 bits, upper byte reads zero; interpretation follows the direct flag
    logic jerk_we;
    logic [1:0] jerk_waddr;
    logic [1:0] jerk_raddr;
    logic [7:0] rd_idx;
    logic [31:0] jerk_wword;

    assign jerk_we = wr_fire && wr_hit && is_jerk(wr_idx);
    assign jerk_waddr = 2'(wr_idx - ESIRS_IDX_JERK1);
    assign jerk_wword = merge({8'h00, 24'h00_0000}, wdata_q, wstrb_q);

    esirs_jerk_mem #(
        .DEPTH(4),
        .WIDTH(ESIRS_JERK_W)
    ) u_jerk (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .wr_en_i(jerk_we),
        .wr_addr_i(jerk_waddr),
        .wr_data_i(jerk_wword[23:0]),
        .rd_addr_i(jerk_raddr),
        .rd_data_o(jerk_rd)
    );

    // ==================================================
    // Read channel: address taken, memory read one cycle, answer next
    logic rd_busy_q;
    logic rd_stage_q;
    logic rd_fetch_q;
    logic [ADDR_W-1:0] araddr_q;

    assign rd_idx = word_index(araddr_q);
    assign jerk_raddr = 2'(rd_idx - ESIRS_IDX_JERK1);

    always_comb begin
        rdata_d = 32'h0000_0000;
        rd_ok_d = (araddr_q[1:0] == 2'b00) && araddr_q[ADDR_W-1:10] == '0;
        if (is_jerk(rd_idx)) begin
            rdata_d = {8'h00, jerk_rd};
        end else begin
            case (rd_idx)
                ESIRS_IDX_GEN_CONF: rdata_d = gen_conf_q;
                ESIRS_IDX_GEARING: rdata_d = gearing_q;
                ESIRS_IDX_CLOCK_FREQUENCY_SETTING: rdata_d = clock_frequency_setting_q;
                ESIRS_IDX_STATUS: rdata_d = {29'h0, ext_mode_o, dir_pos_o, step_o};
                ESIRS_IDX_STEP_CNT: rdata_d = step_cnt_q;
                default: rd_ok_d = 1'b0;
            endcase
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_busy_q <= 1'b0;
            rd_stage_q <= 1'b0;
            rd_fetch_q <= 1'b0;
            araddr_q <= '0;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= AXI_OKAY;
        end else begin
            s_axi_arready <= !rd_busy_q && !s_axi_arready;
            rd_stage_q <= 1'b0;
            // Jerk memory output is registered: wait one more cycle for it
            rd_fetch_q <= rd_stage_q;
            if (s_axi_arvalid && s_axi_arready) begin
                rd_busy_q <= 1'b1;
                rd_stage_q <= 1'b1;
                araddr_q <= s_axi_araddr;
                s_axi_arready <= 1'b0;
            end
            if (rd_fetch_q) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rdata_d;
                s_axi_rresp <= rd_ok_d ? AXI_OKAY : AXI_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                rd_busy_q <= 1'b0;
            end
        end
    end

    // ==================================================
    // Step/direction front end
    logic step_s;
    logic dir_s;
    logic step_prev_q;
    logic ext_edge;
    esirs_src_e src_mode;
    logic pol_dir;

    esirs_sync u_sync_step (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .async_i(ext_step_pin_i),
        .sync_o(step_s)
    );

    esirs_sync u_sync_dir (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .async_i(ext_direction_pin_i),
        .sync_o(dir_s)
    );

    assign src_mode = esirs_src_e'(gen_conf_q[ESIRS_SDIN_MODE_LSB +: 2]);
    assign pol_dir = gen_conf_q[ESIRS_POL_DIR_BIT];

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            step_prev_q <= 1'b0;
        end else begin
            step_prev_q <= step_s;
        end
    end

    always_comb begin
        case (src_mode)
            ESIRS_SRC_RISE: ext_edge = step_s && !step_prev_q;
            ESIRS_SRC_FALL: ext_edge = !step_s && step_prev_q;
            ESIRS_SRC_TOGGLE: ext_edge = step_s != step_prev_q;
            default: ext_edge = 1'b0;
        endcase
    end

    // Internal generator is muted while any external mode is chosen
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            step_o <= 1'b0;
            dir_pos_o <= 1'b0;
            ext_mode_o <= 1'b0;
        end else begin
            ext_mode_o <= src_mode != ESIRS_SRC_INTERNAL;
            if (src_mode != ESIRS_SRC_INTERNAL) begin
                step_o <= ext_edge;
                dir_pos_o <= dir_s ^ pol_dir;
            end else begin
                step_o <= int_step_i;
                dir_pos_o <= int_dir_pos_i;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            step_cnt_q <= '0;
        end else if (src_mode != ESIRS_SRC_INTERNAL && ext_edge) begin
            step_cnt_q <= step_cnt_q + 32'd1;
        end
    end

    // Scaling selectors for the ramp arithmetic
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            direct_jerk_o <= 1'b0;
            direct_accel_o <= 1'b0;
            gearing_factor_o <= ESIRS_GEARING_RST;
            clock_frequency_setting_o <= ESIRS_CLOCK_FREQUENCY_SETTING_RST;
        end else begin
            direct_jerk_o <= gen_conf_q[ESIRS_DIRECT_BOW_BIT];
            direct_accel_o <= gen_conf_q[ESIRS_DIRECT_ACC_BIT];
            gearing_factor_o <= gearing_q;
            clock_frequency_setting_o <= clock_frequency_setting_q;
        end
    end
endmodule

// *** verif/esirs_top_sva.sv ***
// Assertion checker for the external step front end
`timescale 1ns/1ps
module esirs_chk (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic ext_step_pin_i,
    input wire logic ext_direction_pin_i,
    input wire logic int_step_i,
    input wire logic step_o,
    input wire logic dir_pos_o,
    input wire logic ext_mode_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    // ==================================================
    // Pin history, long enough to cover the input pipeline
    logic [6:0] pin_hist_q;
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_hist_q <= 7'h00;
        end else begin
            pin_hist_q <= {pin_hist_q[5:0], ext_step_pin_i};
        end
    end
    // ==================================================
    // Assertions
    int_path_a:
        assert property (!ext_mode_o && !$past(ext_mode_o) && !$past(ext_mode_o, 2)
            |-> step_o == $past(int_step_i)) else $error("step out not following internal step");
    int_block_a:
        assert property ((ext_mode_o && $stable(ext_step_pin_i)) [*6] |-> !step_o)
            else $error("step out without an external edge");
    step_cause_a:
        assert property (ext_mode_o && $past(ext_mode_o) && step_o
            |-> |(pin_hist_q[6:1] ^ pin_hist_q[5:0])) else $error("step with no recent pin change");
    dir_hold_a:
        assert property ((ext_mode_o && !s_axi_wvalid && $stable(ext_direction_pin_i)) [*6]
            |-> $stable(dir_pos_o)) else $error("direction moved with a quiet pin");
    rd_lat_a:
        assert property (s_axi_arvalid && s_axi_arready |-> ##[2:3] s_axi_rvalid)
            else $error("read answer late");
    wr_resp_a:
        assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
            |-> ##[1:3] s_axi_bvalid) else $error("write answer late");
    b_drop_a:
        assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
            else $error("write answer repeated");
    r_drop_a:
        assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
            else $error("read answer repeated");
    cover property (ext_mode_o && step_o);
    cover property (!ext_mode_o && step_o);
    cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
endmodule

bind esirs_top esirs_chk chk_u (
    .core_clk_i, .rst_n_i, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .s_axi_rready, .ext_step_pin_i, .ext_direction_pin_i, .int_step_i,
    .step_o, .dir_pos_o, .ext_mode_o
);

// *** verif/esirs_src_model.sv ***
// Model of another motion controller driving the step and direction pins
`timescale 1ns/1ps
module esirs_src_model (
    input wire logic core_clk_i,
    output logic ext_step_pin_o,
    output logic ext_direction_pin_o
);
    initial begin
        ext_step_pin_o = 1'b0;
        ext_direction_pin_o = 1'b0;
    end
    // ==================================================
    // Whole pulses; each level lasts at least gap cycles so the synchroniser sees it
    task automatic pulse(input int n, input int gap);
        repeat (n) begin
            @(posedge core_clk_i);
            ext_step_pin_o <= 1'b1;
            repeat (gap) @(posedge core_clk_i);
            ext_step_pin_o <= 1'b0;
            repeat (gap) @(posedge core_clk_i);
        end
    endtask
    task automatic set_dir(input logic d);
        @(posedge core_clk_i);
        ext_direction_pin_o <= d;
    endtask
endmodule

// *** verif/tb_top.sv ***
// Self-checking testbench for the external step front end
`timescale 1ns/1ps
module tb_top;
    import esirs_pkg::*;
    logic core_clk_i, rst_n_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_rready, int_step_i, int_dir_pos_i, ext_step_pin_i, ext_direction_pin_i;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, gearing_factor_o, clock_frequency_setting_o;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic step_o, dir_pos_o, ext_mode_o, direct_jerk_o, direct_accel_o;
    int miscompares = 0, n_compared = 0, n_steps = 0, cyc = 0;

    esirs_top dut_u (
        .core_clk_i, .rst_n_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .ext_step_pin_i, .ext_direction_pin_i, .int_step_i,
        .int_dir_pos_i, .step_o, .dir_pos_o, .ext_mode_o, .direct_jerk_o, .direct_accel_o,
        .gearing_factor_o, .clock_frequency_setting_o
    );
    esirs_src_model src_u (
        .core_clk_i,
        .ext_step_pin_o(ext_step_pin_i),
        .ext_direction_pin_o(ext_direction_pin_i)
    );

    initial begin
        core_clk_i = 1'b0;
        forever #2.5 core_clk_i = ~core_clk_i;
    end
    // Hang guard, far above the few hundred cycles the tests need
    always @(posedge core_clk_i) begin
        cyc++;
        if (step_o === 1'b1) n_steps++;
        if (cyc == 20000) begin
            miscompares++;
            end_of_test();
        end
    end
    // ==================================================
    // Shared tasks
    function automatic logic [11:0] ba(input logic [7:0] idx);
        return {2'b00, idx, 2'b00};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        $display("compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge core_clk_i);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge core_clk_i);
            if (s_axi_awready === 1'b1 && !aw_ok) begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wready === 1'b1 && !w_ok) begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge core_clk_i); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk(32'(s_axi_bresp), 32'(er));
    endtask
    task automatic axi_rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge core_clk_i);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge core_clk_i); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge core_clk_i); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        chk(32'(s_axi_rresp), 32'(er));
        if (er == AXI_OKAY) chk(s_axi_rdata, ed);
    endtask
    // ==================================================
    // Scenarios
    task automatic t_reset();
        chk(gearing_factor_o, ESIRS_GEARING_RST);
        chk(clock_frequency_setting_o, ESIRS_CLOCK_FREQUENCY_SETTING_RST);
        axi_rd(ba(ESIRS_IDX_GEN_CONF), ESIRS_GEN_CONF_RST, AXI_OKAY);
        axi_rd(ba(ESIRS_IDX_GEARING), ESIRS_GEARING_RST, AXI_OKAY);
        axi_rd(ba(ESIRS_IDX_CLOCK_FREQUENCY_SETTING), ESIRS_CLOCK_FREQUENCY_SETTING_RST, AXI_OKAY);
        axi_rd(ba(ESIRS_IDX_JERK1), 32'(ESIRS_JERK_RST), AXI_OKAY);
        $display("test reset done");
    endtask
    task automatic t_regs();
        axi_wr(ba(ESIRS_IDX_GEARING), 32'hFF80_0001, AXI_OKAY);
        axi_rd(ba(ESIRS_IDX_GEARING), 32'hFF80_0001, AXI_OKAY);
        chk(gearing_factor_o, 32'hFF80_0001);
        for (int i = 0; i < 4; i++) begin
            axi_wr(ba(ESIRS_IDX_JERK1 + 8'(i)), 32'hAB12_3450 + i, AXI_OKAY);
            axi_rd(ba(ESIRS_IDX_JERK1 + 8'(i)), 32'h0012_3450 + i, AXI_OKAY);
        end
        axi_wr(ba(ESIRS_IDX_GEN_CONF), 32'h0400_0200, AXI_OKAY);
        // Selector outputs are registered one edge after the register write
        @(posedge core_clk_i);
        chk(32'(direct_jerk_o), 32'h0000_0001);
        chk(32'(direct_accel_o), 32'h0000_0001);
        axi_wr(ba(ESIRS_IDX_JERK1), 32'(ESIRS_DIRECT_JERK_MAX), AXI_OKAY);
        axi_rd(ba(ESIRS_IDX_JERK1), 32'(ESIRS_DIRECT_JERK_MAX), AXI_OKAY);
        axi_wr(ba(ESIRS_IDX_CLOCK_FREQUENCY_SETTING), 32'h01E8_4800, AXI_OKAY);
        axi_rd(ba(ESIRS_IDX_CLOCK_FREQUENCY_SETTING), 32'h01E8_4800, AXI_OKAY);
        chk(clock_frequency_setting_o, 32'h01E8_4800);
        axi_wr(12'hFFC, 32'h1234_5678, AXI_SLVERR);
        axi_rd(12'hFFC, 32'h0000_0000, AXI_SLVERR);
        axi_wr(ba(ESIRS_IDX_GEARING) + 12'h002, 32'h0000_0001, AXI_SLVERR);
        axi_rd(ba(ESIRS_IDX_GEARING), 32'hFF80_0001, AXI_OKAY);
        axi_wr(ba(ESIRS_IDX_GEN_CONF), 32'h0000_0000, AXI_OKAY);
        @(posedge core_clk_i);
        chk(32'(direct_jerk_o), 32'h0000_0000);
        $display("test registers done");
    endtask
    task automatic t_modes();
        int exp_n [4] = '{2, 3, 3, 6};
        for (int m = 0; m < 4; m++) begin
            axi_wr(ba(ESIRS_IDX_GEN_CONF), 32'(m) << ESIRS_SDIN_MODE_LSB, AXI_OKAY);
            repeat (8) @(posedge core_clk_i);
            chk(32'(ext_mode_o), 32'(m != 0));
            n_steps = 0;
            src_u.pulse(3, 4);
            repeat (2) begin
                @(posedge core_clk_i);
                int_step_i <= 1'b1;
                @(posedge core_clk_i);
                int_step_i <= 1'b0;
            end
            repeat (10) @(posedge core_clk_i);
            chk(32'(n_steps), 32'(exp_n[m]));
        end
        // Only external edges count: 3 rising, 3 falling, 6 toggles
        axi_rd(ba(ESIRS_IDX_STEP_CNT), 32'h0000_000C, AXI_OKAY);
        axi_rd(ba(ESIRS_IDX_STATUS), 32'h0000_0004, AXI_OKAY);
        $display("test step modes done");
    endtask
    task automatic t_dir();
        for (int k = 0; k < 4; k++) begin
            axi_wr(ba(ESIRS_IDX_GEN_CONF),
                32'h0000_0040 | (32'(k[1]) << ESIRS_POL_DIR_BIT), AXI_OKAY);
            src_u.set_dir(k[0]);
            repeat (8) @(posedge core_clk_i);
            chk(32'(dir_pos_o), 32'(k[0] ^ k[1]));
        end
        axi_wr(ba(ESIRS_IDX_GEN_CONF), 32'h0000_0000, AXI_OKAY);
        int_dir_pos_i <= 1'b1;
        repeat (6) @(posedge core_clk_i);
        chk(32'(dir_pos_o), 32'h0000_0001);
        $display("test direction done");
    endtask

    initial begin
        rst_n_i = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {int_step_i, int_dir_pos_i} = 2'b00;
        s_axi_awaddr = 12'h000;
        s_axi_araddr = 12'h000;
        s_axi_wdata = 32'h0000_0000;
        s_axi_wstrb = 4'hF;
        repeat (16) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        @(posedge core_clk_i);
        t_reset();
        t_regs();
        t_modes();
        t_dir();
        end_of_test();
    end
endmodule
